/* core/descr_link_if.sv */
/*
 * carrier between the receive core and its descrambler: serial scrambled
 * bits in, serial descrambled bits and lock state out.
 * assumes: both ends run on the same core clock.
 */
`timescale 1ns/100ps
interface descr_link_if;
   logic bit_stb;
   logic sd_bit;
   logic bypass;
   logic ud_stb;
   logic ud_bit;
   logic locked;

   modport core  (output bit_stb, output sd_bit, output bypass,
                  input  ud_stb,  input  ud_bit, input  locked);
   modport descr (input  bit_stb, input  sd_bit, input  bypass,
                  output ud_stb,  output ud_bit, output locked);
endinterface

/* core/descrambler_lock.sv */
/*
 * serial descrambler with idle-trained lock, line state monitor and hold
 * timer.
 * assumes: bit_stb is a one-cycle strobe per received bit, on clk_in.
 */
`timescale 1ns/100ps
module descrambler_lock #(
   parameter int HOLD_CYCLES = fe_rx_pkg::HOLD_CYCLES
) (
   input  wire logic  clk_in,
   input  wire logic  rst_b_in,
   descr_link_if.descr dif
);

   logic [10:0] lfsr_r,   lfsr_nxt;
   logic [5:0]  match_r,  match_nxt;
   logic [5:0]  ones_r,   ones_nxt;
   logic [15:0] hold_r,   hold_nxt;
   logic        locked_r, locked_nxt;
   logic        ud_r,     ud_nxt;
   logic        stb_r,    stb_nxt;
   logic        key;

   assign key = lfsr_r[fe_rx_pkg::LFSR_TAP_HI] ^
                lfsr_r[fe_rx_pkg::LFSR_TAP_LO];

   always_comb begin
      lfsr_nxt   = lfsr_r;
      match_nxt  = match_r;
      ones_nxt   = ones_r;
      hold_nxt   = hold_r;
      locked_nxt = locked_r;
      ud_nxt     = ud_r;
      stb_nxt    = dif.bit_stb;
      if (dif.bypass) begin
         locked_nxt = 1'b1;
         ud_nxt     = dif.sd_bit;
         match_nxt  = '0;
         ones_nxt   = '0;
         hold_nxt   = '0;
      end else if (!locked_r) begin
         if (dif.bit_stb) begin
            lfsr_nxt = {lfsr_r[9:0], ~dif.sd_bit};
            ud_nxt   = 1'b1;
            if (key == ~dif.sd_bit) begin
               match_nxt = match_r + 6'h01;
            end else begin
               match_nxt = '0;
            end
            if (match_r == 6'(fe_rx_pkg::LOCK_BITS - 1) &&
                key == ~dif.sd_bit) begin
               locked_nxt = 1'b1;
               match_nxt  = '0;
               ones_nxt   = '0;
               hold_nxt   = 16'(HOLD_CYCLES);
            end
         end
      end else begin
         hold_nxt = hold_r - 16'h0001;
         if (dif.bit_stb) begin
            lfsr_nxt = {lfsr_r[9:0], key};
            ud_nxt   = dif.sd_bit ^ key;
            if (dif.sd_bit ^ key) begin
               ones_nxt = ones_r + 6'h01;
            end else begin
               ones_nxt = '0;
            end
            if (ones_r == 6'(fe_rx_pkg::LSM_IDLE_BITS - 1) &&
                (dif.sd_bit ^ key)) begin
               ones_nxt = '0;
               hold_nxt = 16'(HOLD_CYCLES);
            end
         end
         if (hold_r == 16'h0000) begin
            locked_nxt = 1'b0;
            lfsr_nxt   = fe_rx_pkg::LFSR_RESET;
            match_nxt  = '0;
            ones_nxt   = '0;
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         lfsr_r   <= fe_rx_pkg::LFSR_RESET;
         match_r  <= '0;
         ones_r   <= '0;
         hold_r   <= '0;
         locked_r <= 1'b0;
         ud_r     <= 1'b0;
         stb_r    <= 1'b0;
      end else begin
         lfsr_r   <= lfsr_nxt;
         match_r  <= match_nxt;
         ones_r   <= ones_nxt;
         hold_r   <= hold_nxt;
         locked_r <= locked_nxt;
         ud_r     <= ud_nxt;
         stb_r    <= stb_nxt;
      end
   end

   assign dif.ud_stb = stb_r;
   assign dif.ud_bit = ud_r;
   assign dif.locked = locked_r;

endmodule // descrambler_lock

/* core/fast_ethernet_rx_pcs.sv */
/*
 * fast ethernet receive coding path: nrzi decode, descramble, code-group
 * alignment, 4b/5b decode to nibbles, link monitor, bad start detection.
 * assumes: the recovered bit clock and nrzi data arrive as pins far slower
 * than clk_in; the energy detect pin comes from the analog front end.
 */
`timescale 1ns/100ps
module fast_ethernet_rx_pcs #(
   parameter int HOLD_CYCLES = fe_rx_pkg::HOLD_CYCLES,
   parameter int LINK_CYCLES = fe_rx_pkg::LINK_CYCLES
) (
   input  wire logic        clk_in,
   input  wire logic        rst_b_in,
   input  wire logic        rx_bit_clk_in,
   input  wire logic        rx_nrzi_in,
   input  wire logic        sig_energy_in,
   input  wire logic        descr_bypass_in,
   input  wire logic        rx_bypass_in,
   output logic             rx_clk_out,
   output logic [3:0]       rxd_out,
   output logic             rx_dv_out,
   output logic             rx_er_out,
   output logic             crs_out,
   output logic [4:0]       sym_out,
   output logic             sym_valid_out,
   output logic             sig_detect_out,
   output logic             link_up_out,
   output logic             descr_locked_out,
   output logic [15:0]      false_carrier_event_counter_out
);

   ////////////////////////////////////////////////////////////////////////
   // decode table: {data valid, nibble}

   function automatic logic [4:0] decode_group(input logic [4:0] cg);
      logic [4:0] res;
      res = {1'b0, fe_rx_pkg::NIB_ZERO};
      case (cg)
         5'h1E: res = 5'h10;
         5'h09: res = 5'h11;
         5'h14: res = 5'h12;
         5'h15: res = 5'h13;
         5'h0A: res = 5'h14;
         5'h0B: res = 5'h15;
         5'h0E: res = 5'h16;
         5'h0F: res = 5'h17;
         5'h12: res = 5'h18;
         5'h13: res = 5'h19;
         5'h16: res = 5'h1A;
         5'h17: res = 5'h1B;
         5'h1A: res = 5'h1C;
         5'h1B: res = 5'h1D;
         5'h1C: res = 5'h1E;
         5'h1D: res = 5'h1F;
         default: res = {1'b0, fe_rx_pkg::NIB_ZERO};
      endcase
      return res;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   logic [4:0] sync1_r;
   logic [4:0] sync2_r;
   logic       bclk_prev_r;
   logic       bit_stb;
   logic       nrzi_s;
   logic       energy_s;
   logic       descr_byp_s;
   logic       rx_byp_s;

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         sync1_r     <= '0;
         sync2_r     <= '0;
         bclk_prev_r <= 1'b0;
      end else begin
         sync1_r     <= {rx_bit_clk_in, rx_nrzi_in, sig_energy_in,
                         descr_bypass_in, rx_bypass_in};
         sync2_r     <= sync1_r;
         bclk_prev_r <= sync2_r[4];
      end
   end

   assign bit_stb     = sync2_r[4] & ~bclk_prev_r;
   assign nrzi_s      = sync2_r[3];
   assign energy_s    = sync2_r[2];
   assign descr_byp_s = sync2_r[1];
   assign rx_byp_s    = sync2_r[0];

   ////////////////////////////////////////////////////////////////////////
   // signal detect qualifier and link monitor

   logic [15:0] sd_cnt_r,   sd_cnt_nxt;
   logic [15:0] link_cnt_r, link_cnt_nxt;
   logic        sd_r,       sd_nxt;
   logic        link_r,     link_nxt;

   always_comb begin
      sd_cnt_nxt   = sd_cnt_r;
      link_cnt_nxt = link_cnt_r;
      sd_nxt       = sd_r;
      link_nxt     = link_r;
      if (!energy_s) begin
         sd_cnt_nxt = '0;
         sd_nxt     = 1'b0;
      end else if (sd_cnt_r == 16'(fe_rx_pkg::SD_QUAL_CYCLES - 1)) begin
         sd_nxt     = 1'b1;
      end else begin
         sd_cnt_nxt = sd_cnt_r + 16'h0001;
      end
      if (!sd_r) begin
         link_cnt_nxt = '0;
         link_nxt     = 1'b0;
      end else if (link_cnt_r == 16'(LINK_CYCLES - 1)) begin
         link_nxt     = 1'b1;
      end else begin
         link_cnt_nxt = link_cnt_r + 16'h0001;
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         sd_cnt_r   <= '0;
         link_cnt_r <= '0;
         sd_r       <= 1'b0;
         link_r     <= 1'b0;
      end else begin
         sd_cnt_r   <= sd_cnt_nxt;
         link_cnt_r <= link_cnt_nxt;
         sd_r       <= sd_nxt;
         link_r     <= link_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // nrzi decode and descrambler

   logic         nrzi_prev_r, nrzi_prev_nxt;
   logic         nrz_bit;
   descr_link_if dif ();

   assign nrz_bit     = nrzi_s ^ nrzi_prev_r;
   assign dif.bit_stb = bit_stb;
   assign dif.sd_bit  = nrz_bit;
   assign dif.bypass  = descr_byp_s;

   always_comb begin
      nrzi_prev_nxt = bit_stb ? nrzi_s : nrzi_prev_r;
   end

   descrambler_lock #(
      .HOLD_CYCLES (HOLD_CYCLES)
   ) u_descr (
      .clk_in   (clk_in),
      .rst_b_in (rst_b_in),
      .dif      (dif)
   );

   ////////////////////////////////////////////////////////////////////////
   // alignment, decode and bad start detection

   fe_rx_pkg::dec_state_e state_r, state_nxt;
   logic [9:0]  sr_r,      sr_nxt;
   logic [2:0]  bitcnt_r,  bitcnt_nxt;
   logic [2:0]  wait_r,    wait_nxt;
   logic [3:0]  ones_r,    ones_nxt;
   logic        idle2_r,   idle2_nxt;
   logic [3:0]  hold_r,    hold_nxt;
   logic        hold_er_r, hold_er_nxt;
   logic        rxclk_r,   rxclk_nxt;
   logic [3:0]  rxd_r,     rxd_nxt;
   logic        dv_r,      dv_nxt;
   logic        er_r,      er_nxt;
   logic        crs_r,     crs_nxt;
   logic [4:0]  sym_r,     sym_nxt;
   logic        symv_r,    symv_nxt;
   logic [15:0] fcc_r,     fcc_nxt;
   logic        stb;
   logic        sbit;
   logic        grp_done;
   logic [4:0]  grp;
   logic [4:0]  dec;

   // raw bypass groups the nrz stream with a free boundary
   assign stb      = rx_byp_s ? bit_stb : dif.ud_stb;
   assign sbit     = rx_byp_s ? nrz_bit : dif.ud_bit;
   assign grp_done = (bitcnt_r == fe_rx_pkg::LAST_BIT);
   assign grp      = sr_nxt[4:0];
   assign dec      = decode_group(grp);

   always_comb begin
      state_nxt   = state_r;
      sr_nxt      = sr_r;
      bitcnt_nxt  = bitcnt_r;
      wait_nxt    = wait_r;
      ones_nxt    = ones_r;
      idle2_nxt   = idle2_r;
      hold_nxt    = hold_r;
      hold_er_nxt = hold_er_r;
      rxclk_nxt   = rxclk_r;
      rxd_nxt     = rxd_r;
      dv_nxt      = dv_r;
      er_nxt      = er_r;
      crs_nxt     = crs_r;
      sym_nxt     = sym_r;
      symv_nxt    = 1'b0;
      fcc_nxt     = fcc_r;
      if (stb) begin
         sr_nxt     = {sr_r[8:0], sbit};
         bitcnt_nxt = grp_done ? 3'h0 : bitcnt_r + 3'h1;
         // nibble clock is bit clock over five
         rxclk_nxt  = (bitcnt_nxt < fe_rx_pkg::RXCLK_HIGH_BITS);
         if (sbit) begin
            ones_nxt = (ones_r == 4'(fe_rx_pkg::PRE_IDLE_BITS)) ?
                       ones_r : ones_r + 4'h1;
         end else begin
            ones_nxt = '0;
         end
         if (grp_done) begin
            sym_nxt  = grp;
            symv_nxt = 1'b1;
         end
         if (rx_byp_s || !dif.locked || !link_r) begin
            // coding layer held off until link up and descrambler lock, and in raw bypass
            state_nxt = fe_rx_pkg::ST_HUNT;
            dv_nxt    = 1'b0;
            er_nxt    = 1'b0;
            crs_nxt   = 1'b0;
            rxd_nxt   = fe_rx_pkg::NIB_ZERO;
         end else begin
            unique case (state_r)
               fe_rx_pkg::ST_HUNT: begin
                  if (!sbit &&
                      ones_r == 4'(fe_rx_pkg::PRE_IDLE_BITS)) begin
                     state_nxt = fe_rx_pkg::ST_CAND;
                     wait_nxt  = '0;
                  end
               end
               fe_rx_pkg::ST_CAND: begin
                  wait_nxt = wait_r + 3'h1;
                  if (wait_r == fe_rx_pkg::SSD_TAIL_BITS - 3'h1) begin
                     bitcnt_nxt = 3'h0;
                     rxclk_nxt  = 1'b1;
                     idle2_nxt  = 1'b0;
                     crs_nxt    = 1'b1;
                     if (sr_nxt == fe_rx_pkg::CG_JK) begin
                        state_nxt   = fe_rx_pkg::ST_PKT;
                        rxd_nxt     = fe_rx_pkg::NIB_PREAMBLE;
                        dv_nxt      = 1'b1;
                        hold_nxt    = fe_rx_pkg::NIB_PREAMBLE;
                        hold_er_nxt = 1'b0;
                     end else begin
                        state_nxt = fe_rx_pkg::ST_FALSE;
                        rxd_nxt   = fe_rx_pkg::NIB_BAD_SSD;
                        er_nxt    = 1'b1;
                        fcc_nxt   = fcc_r + 16'h0001;
                     end
                  end
               end
               fe_rx_pkg::ST_PKT: begin
                  if (grp_done) begin
                     // one group late so both preamble nibbles fit
                     rxd_nxt     = hold_r;
                     er_nxt      = hold_er_r;
                     dv_nxt      = 1'b1;
                     hold_nxt    = dec[3:0];
                     hold_er_nxt = 1'b0;
                     idle2_nxt   = 1'b0;
                     if (grp == fe_rx_pkg::CG_T) begin
                        state_nxt = fe_rx_pkg::ST_END;
                     end else if (grp == fe_rx_pkg::CG_IDLE) begin
                        if (idle2_r) begin
                           state_nxt = fe_rx_pkg::ST_HUNT;
                           dv_nxt    = 1'b0;
                           er_nxt    = 1'b0;
                           crs_nxt   = 1'b0;
                        end
                        idle2_nxt   = 1'b1;
                        hold_er_nxt = 1'b1;
                     end else if (!dec[4]) begin
                        hold_er_nxt = 1'b1;
                     end
                  end
               end
               fe_rx_pkg::ST_END: begin
                  if (grp_done) begin
                     if (grp == fe_rx_pkg::CG_R) begin
                        state_nxt = fe_rx_pkg::ST_HUNT;
                        dv_nxt    = 1'b0;
                        er_nxt    = 1'b0;
                        crs_nxt   = 1'b0;
                        rxd_nxt   = fe_rx_pkg::NIB_ZERO;
                     end else begin
                        // lone end group is corrupt data
                        state_nxt   = fe_rx_pkg::ST_PKT;
                        rxd_nxt     = fe_rx_pkg::NIB_ZERO;
                        er_nxt      = 1'b1;
                        hold_nxt    = dec[3:0];
                        hold_er_nxt = ~dec[4];
                     end
                  end
               end
               fe_rx_pkg::ST_FALSE: begin
                  if (grp_done) begin
                     rxd_nxt   = fe_rx_pkg::NIB_BAD_SSD;
                     er_nxt    = 1'b1;
                     idle2_nxt = (grp == fe_rx_pkg::CG_IDLE);
                     if (grp == fe_rx_pkg::CG_IDLE && idle2_r) begin
                        state_nxt = fe_rx_pkg::ST_HUNT;
                        rxd_nxt   = fe_rx_pkg::NIB_ZERO;
                        er_nxt    = 1'b0;
                        crs_nxt   = 1'b0;
                     end
                  end
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         nrzi_prev_r <= 1'b0;
         state_r     <= fe_rx_pkg::ST_HUNT;
         sr_r        <= '0;
         bitcnt_r    <= '0;
         wait_r      <= '0;
         ones_r      <= '0;
         idle2_r     <= 1'b0;
         hold_r      <= '0;
         hold_er_r   <= 1'b0;
         rxclk_r     <= 1'b0;
         rxd_r       <= '0;
         dv_r        <= 1'b0;
         er_r        <= 1'b0;
         crs_r       <= 1'b0;
         sym_r       <= '0;
         symv_r      <= 1'b0;
         fcc_r       <= '0;
         descr_locked_out <= 1'b0;
      end else begin
         nrzi_prev_r <= nrzi_prev_nxt;
         state_r     <= state_nxt;
         sr_r        <= sr_nxt;
         bitcnt_r    <= bitcnt_nxt;
         wait_r      <= wait_nxt;
         ones_r      <= ones_nxt;
         idle2_r     <= idle2_nxt;
         hold_r      <= hold_nxt;
         hold_er_r   <= hold_er_nxt;
         rxclk_r     <= rxclk_nxt;
         rxd_r       <= rxd_nxt;
         dv_r        <= dv_nxt;
         er_r        <= er_nxt;
         crs_r       <= crs_nxt;
         sym_r       <= sym_nxt;
         symv_r      <= symv_nxt;
         fcc_r       <= fcc_nxt;
         descr_locked_out <= dif.locked;
      end
   end

   assign rx_clk_out     = rxclk_r;
   assign rxd_out        = rxd_r;
   assign rx_dv_out      = dv_r;
   assign rx_er_out      = er_r;
   assign crs_out        = crs_r;
   assign sym_out        = sym_r;
   assign sym_valid_out  = symv_r;
   assign sig_detect_out = sd_r;
   assign link_up_out    = link_r;
   assign false_carrier_event_counter_out = fcc_r;

endmodule // fast_ethernet_rx_pcs

/* core/fe_rx_pkg.sv */
/*
 * shared constants for the fast ethernet receive coding path: code-groups,
 * nibble values, lock and hold figures, and timing counts derived from the
 * 10 MHz core clock.
 * assumes: every user writes fe_rx_pkg::name, nothing is imported.
 */
package fe_rx_pkg;

   localparam int          CLK_KHZ          = 10000;
   localparam int          SYM_W            = 5;
   localparam int          NIB_W            = 4;
   localparam int          LFSR_W           = 11;
   localparam int          FCC_W            = 16;

   // control code-groups, first received bit on the left
   localparam logic [4:0]  CG_IDLE          = 5'h1F;
   localparam logic [4:0]  CG_J             = 5'h18;
   localparam logic [4:0]  CG_K             = 5'h11;
   localparam logic [4:0]  CG_T             = 5'h0D;
   localparam logic [4:0]  CG_R             = 5'h07;
   localparam logic [4:0]  CG_H             = 5'h04;
   localparam logic [9:0]  CG_JK            = {CG_J, CG_K};

   localparam logic [3:0]  NIB_PREAMBLE     = 4'h5;
   localparam logic [3:0]  NIB_BAD_SSD      = 4'hE;
   localparam logic [3:0]  NIB_ZERO         = 4'h0;

   // key generator taps for x^11 + x^9 + 1
   localparam int          LFSR_TAP_HI      = 10;
   localparam int          LFSR_TAP_LO      = 8;
   localparam logic [10:0] LFSR_RESET       = 11'h7FF;

   localparam int          LOCK_IDLE_GROUPS = 12;
   localparam int          LOCK_BITS        = LOCK_IDLE_GROUPS * SYM_W;
   localparam int          LSM_IDLE_BITS    = 58;
   localparam int          PRE_IDLE_BITS    = 2 * SYM_W;
   // bits of the start pair that follow its first zero
   localparam logic [2:0]  SSD_TAIL_BITS    = 3'h7;
   localparam logic [2:0]  LAST_BIT         = 3'h4;
   localparam logic [2:0]  RXCLK_HIGH_BITS  = 3'h3;

   // longest time: rounds down
   localparam int          HOLD_TIME_US     = 722;
   localparam int          HOLD_CYCLES      = HOLD_TIME_US * CLK_KHZ / 1000;
   // least times: round up
   localparam int          LINK_TIME_US     = 395;
   localparam int          LINK_CYCLES      =
      (LINK_TIME_US * CLK_KHZ + 999) / 1000;
   localparam int          SD_QUAL_NS       = 400;
   localparam int          SD_QUAL_CYCLES   =
      (SD_QUAL_NS * CLK_KHZ + 999999) / 1000000;

   typedef enum logic [2:0] {
      ST_HUNT,
      ST_CAND,
      ST_PKT,
      ST_END,
      ST_FALSE
   } dec_state_e;

endpackage

/* testbench/fast_ethernet_rx_pcs_tb.sv */
/* self-checking bench: scrambled nrzi line in, mac model on the nibbles.
   assumes: short hold and link counts set at the instance. */
`timescale 1ns/100ps
module fast_ethernet_rx_pcs_tb;
   logic clk_in = 0, rst_b_in = 0, bclk = 0, nrzi = 0, energy = 0;
   logic byp = 0, rbyp = 0, scr = 1;
   logic rx_clk, dv, er, crs, sv, sd, lu, lk;
   logic [3:0] rxd;
   logic [4:0] sym;
   logic [15:0] fcc, f0;
   logic [10:0] key;
   logic [3:0] exp_q[$];
   int fails = 0, n_tests = 0, e0;
   always #50 clk_in = ~clk_in;
   fast_ethernet_rx_pcs #(.HOLD_CYCLES(2000), .LINK_CYCLES(50)) i_dut (
      .clk_in(clk_in), .rst_b_in(rst_b_in), .rx_bit_clk_in(bclk),
      .rx_nrzi_in(nrzi), .sig_energy_in(energy), .descr_bypass_in(byp),
      .rx_bypass_in(rbyp), .rx_clk_out(rx_clk), .rxd_out(rxd),
      .rx_dv_out(dv), .rx_er_out(er), .crs_out(crs), .sym_out(sym),
      .sym_valid_out(sv), .sig_detect_out(sd), .link_up_out(lu),
      .descr_locked_out(lk), .false_carrier_event_counter_out(fcc));
   mac_rx_model i_mac (.rx_clk_in(rx_clk), .rxd_in(rxd), .rx_dv_in(dv),
      .rx_er_in(er));
//////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic [4:0] enc(input logic [3:0] n);
      logic [4:0] t[16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E,
         5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
      return t[n];
   endfunction
   // one group, first bit first; bit clock only runs while sending
   task automatic grp(input logic [4:0] g);
      logic n;
      for (int i = 4; i >= 0; i--) begin
         n = key[10] ^ key[8];
         key = {key[9:0], n};
         // key keeps running while unscrambled, so lock can retrain later
         nrzi = nrzi ^ g[i] ^ (n & scr);
         #200 bclk = 1'b1;
         #400 bclk = 1'b0;
         #200;
      end
   endtask
   task automatic idles(input int k);
      repeat (k) grp(fe_rx_pkg::CG_IDLE);
   endtask
   task automatic pkt(input bit bad);
      logic [3:0] d;
      i_mac.nib_q.delete();
      e0 = i_mac.er_cnt;
      exp_q = '{4'h5, 4'h5};
      idles(4);
      grp(fe_rx_pkg::CG_J);
      grp(fe_rx_pkg::CG_K);
      for (int k = 0; k < 8; k++) begin
         d = 4'($urandom);
         exp_q.push_back(d);
         grp((bad && k == 3) ? fe_rx_pkg::CG_H : enc(d));
      end
      grp(fe_rx_pkg::CG_T);
      grp(fe_rx_pkg::CG_R);
      idles(12);
      chk(16'(i_mac.er_cnt != e0), 16'(bad));
      if (!bad) begin
         chk(16'(i_mac.nib_q.size()), 16'd10);
         foreach (exp_q[i]) chk(16'(i_mac.nib_q[i]), 16'(exp_q[i]));
      end
      chk(16'(crs), 16'h0);
   endtask
   task automatic give_verdict();
      $display("compares %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #2000000;
      fails++;
      give_verdict();
   end
   initial begin
      void'($urandom(32'h9E0E));
      key = 11'($urandom) | 11'h001;
      repeat (5) @(negedge clk_in);
      rst_b_in = 1'b1;
      energy = 1'b1;
      @(negedge clk_in) energy = 1'b0;
      repeat (10) @(negedge clk_in);
      chk(16'(sd), 16'h0);
      energy = 1'b1;
      repeat (25) @(negedge clk_in);
      chk(16'(lu), 16'h0);
      repeat (40) @(negedge clk_in);
      chk(16'(lu), 16'h1);
      $display("test link done");
      byp = 1'b1;
      scr = 1'b0;
      pkt(1'b0);
      rbyp = 1'b1;
      repeat (3) grp(5'h00);
      chk(16'(sym), 16'h0000);
      idles(2);
      chk(16'(sym), 16'(fe_rx_pkg::CG_IDLE));
      rbyp = 1'b0;
      byp = 1'b0;
      scr = 1'b1;
      $display("test bypass done");
      idles(5);
      chk(16'(lk), 16'h0);
      idles(25);
      chk(16'(lk), 16'h1);
      $display("test lock done");
      pkt(1'b0);
      pkt(1'b1);
      $display("test packets done");
      for (int k = 0; k < 2; k++) begin
         f0 = fcc;
         e0 = i_mac.er_cnt;
         idles(4);
         grp(enc(4'h1));
         repeat (3) grp(enc(4'($urandom)));
         idles(12);
         chk(fcc, f0 + 16'h1);
         chk(16'(i_mac.er_cnt > e0), 16'h1);
         chk(16'({er, crs}), 16'h0);
      end
      $display("test false carrier done");
      repeat (2100) @(negedge clk_in);
      chk(16'(lk), 16'h0);
      $display("test hold done");
      give_verdict();
   end
endmodule // fast_ethernet_rx_pcs_tb

/* testbench/fe_rx_pcs_props.sv */
/* port checker for the receive coding path.
   assumes: bound into fast_ethernet_rx_pcs, single core clock. */
`timescale 1ns/100ps
module fe_rx_pcs_props #(
   parameter int LINK_CYCLES = 50
) (
   input wire logic        clk_in,
   input wire logic        rst_b_in,
   input wire logic        sig_energy_in,
   input wire logic        descr_bypass_in,
   input wire logic        rx_clk_out,
   input wire logic [3:0]  rxd_out,
   input wire logic        rx_dv_out,
   input wire logic        rx_er_out,
   input wire logic        crs_out,
   input wire logic        sym_valid_out,
   input wire logic        sig_detect_out,
   input wire logic        link_up_out,
   input wire logic        descr_locked_out,
   input wire logic [15:0] false_carrier_event_counter_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   logic [15:0] run_r;
   logic [15:0] run_nxt;
   // saturating run of signal detect, so long links never wrap
   always_comb run_nxt = sig_detect_out ? run_r + (run_r != 16'hFFFF) : 16'h0;
   always_ff @(posedge clk_in or negedge rst_b_in)
      if (!rst_b_in)
         run_r <= 16'h0000;
      else
         run_r <= run_nxt;
//////////////////////////////////////////////////////////////////////////////
   chk_pulse_reject: assert property (
      $rose(sig_detect_out) |->
      $past(sig_energy_in, 4) && $past(sig_energy_in, 5))
      else $error("signal detect rose on a short pulse");
   chk_link_wait: assert property (
      $rose(link_up_out) |-> run_r >= LINK_CYCLES - 1)
      else $error("link up too early");
   chk_false_nib: assert property (
      crs_out && rx_er_out && !rx_dv_out |-> rxd_out == fe_rx_pkg::NIB_BAD_SSD)
      else $error("false carrier nibble wrong");
   chk_fcc_step: assert property (
      $changed(false_carrier_event_counter_out) |->
      false_carrier_event_counter_out ==
      $past(false_carrier_event_counter_out) + 16'h1)
      else $error("counter step not one");
   chk_fcc_cause: assert property (
      $changed(false_carrier_event_counter_out) |->
      ##[0:2] (rx_er_out && !rx_dv_out))
      else $error("counter moved without false carrier");
   chk_dv_crs: assert property (rx_dv_out |-> crs_out)
      else $error("data valid without carrier");
   chk_lock_gate: assert property (
      !link_up_out || (!descr_locked_out && !descr_bypass_in) |=> !rx_dv_out)
      else $error("data valid while unlocked");
   chk_pre_first: assert property (
      $rose(rx_dv_out) |-> rxd_out == fe_rx_pkg::NIB_PREAMBLE && rx_clk_out)
      else $error("first nibble not preamble");
   chk_sym_pulse: assert property (sym_valid_out |=> !sym_valid_out)
      else $error("symbol strobe too long");
   chk_er_end: assert property ($fell(crs_out) |-> !rx_er_out)
      else $error("error outlived carrier");
endmodule // fe_rx_pcs_props
bind fast_ethernet_rx_pcs fe_rx_pcs_props #(.LINK_CYCLES(LINK_CYCLES)) i_props (
   .clk_in(clk_in), .rst_b_in(rst_b_in), .sig_energy_in(sig_energy_in),
   .descr_bypass_in(descr_bypass_in), .rx_clk_out(rx_clk_out),
   .rxd_out(rxd_out), .rx_dv_out(rx_dv_out), .rx_er_out(rx_er_out),
   .crs_out(crs_out), .sym_valid_out(sym_valid_out),
   .sig_detect_out(sig_detect_out), .link_up_out(link_up_out),
   .descr_locked_out(descr_locked_out),
   .false_carrier_event_counter_out(false_carrier_event_counter_out));

/* testbench/mac_rx_model.sv */
/* receiving mac on the nibble side: keeps valid nibbles and error count.
   assumes: nibbles are stable at the falling receive clock. */
`timescale 1ns/100ps
module mac_rx_model (
   input wire logic       rx_clk_in,
   input wire logic [3:0] rxd_in,
   input wire logic       rx_dv_in,
   input wire logic       rx_er_in
);
   logic [3:0] nib_q[$];
   int         er_cnt = 0;
   always @(negedge rx_clk_in) begin
      if (rx_dv_in === 1'b1)
         nib_q.push_back(rxd_in);
      if (rx_er_in === 1'b1)
         er_cnt++;
   end
endmodule // mac_rx_model
